// ===== rtl/cmr_pkg.sv
// package: register group layout, field positions, reset values, timing
package cmr_pkg;
  // register groups selected by the host-side access port
  typedef enum logic [2:0] {
    GRP_CFG = 3'b000,
    GRP_CELL = 3'b001,
    GRP_FLAG = 3'b010,
    GRP_TEMP = 3'b011,
    GRP_PEC = 3'b100
  } cmr_group_t;

  localparam int CFG_BYTES = 6;
  localparam int CELL_BYTES = 18;
  localparam int FLAG_BYTES = 3;
  localparam int TEMP_BYTES = 5;
  localparam int CELL_COUNT = 12;
  localparam int RES_W = 12;

  // config byte0 field positions, then byte2 mask, temp byte4 fields and first hidden cell byte
  localparam int B0_WDT_BIT = 7;
  localparam int B0_GPIO2_BIT = 6;
  localparam int B0_GPIO1_BIT = 5;
  localparam int B0_POLL_BIT = 4;
  localparam int B0_TEN_BIT = 3;
  localparam int B0_CDC_LSB = 0;
  localparam int B2_MASK_LSB = 4;
  localparam int TMP4_REV_LSB = 5;
  localparam int TMP4_THERMAL_SHUTDOWN_FLAG_BIT = 4;
  localparam int TEN_CELL_FIRST_HIDDEN = 15;

  // reset values of the configuration bytes
  localparam logic [7:0] CFG0_RESET = 8'h60;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  localparam logic [7:0] CFG4_RESET = 8'h00;
  localparam logic [7:0] CFG5_RESET = 8'h00;

  // revision code, value arbitrary
  localparam logic [2:0] REV_CODE = 3'h1;

  // duty-cycle timing in ms
  localparam int CLK_MHZ = 100;
  localparam int MEAS_FAST_MS = 13;
  localparam int MEAS_SLOW_MS = 21;
  localparam int CMP_P13_MS = 13;
  localparam int CMP_P130_MS = 130;
  localparam int CMP_P500_MS = 500;
  localparam int CMP_P2000_MS = 2000;
  localparam logic [31:0] CYC_PER_MS = 32'(CLK_MHZ * 1000);
endpackage

// ===== rtl/cmr_pair_pack.sv
// packs two 12-bit results into three bytes
module cmr_pair_pack (
  input wire logic [11:0] firstRes,  // lower-numbered result
  input wire logic [11:0] secondRes, // higher-numbered result
  output logic [7:0] byteLo,         // first low byte
  output logic [7:0] byteMid,        // shared nibble byte
  output logic [7:0] byteHi          // second high byte
);
  // shared byte: second low nibble on top
  assign byteLo = firstRes[7:0];
  assign byteMid = {secondRes[3:0], firstRes[11:8]};
  assign byteHi = secondRes[11:4];
endmodule // cmr_pair_pack

// ===== rtl/cmr_regmap.sv
// register map of the cell monitor with duty-cycle decode
// How it works
// - config byte0 holds watchdog, gpio2, gpio1, polling, ten-cell, duty.
// - bytes1-5 hold discharge enables, irq masks and the two thresholds.
// - twelve 12-bit cell results pack into eighteen bytes, three per pair.
// - cell bytes 15 to 17 are readable only while ten-cell select is low.
// - three flag bytes, under flag on even bit, over flag on next odd bit.
// - flags of cells 11 and 12 read zero while ten-cell select is high.
// - five temp bytes: two external results paired, internal in bytes 3-4.
// - temp byte4 carries revision in bits 7-5 and shutdown in bit 4.
// - one read-only packet check byte goes with read answers.
// - duty code 0 is standby: comparator off, reference down, no timing.
// - codes 1-4 keep reference up, 13 ms per cell, periods off/13/130/500.
// - codes 5-7 drop reference, 21 ms per cell, periods 130/500/2000.
// - reading the temperature group clears the shutdown status bit.
module cmr_regmap
  import cmr_pkg::*;
(
  input wire logic clk,                          // 100 MHz clock
  input wire logic sys_rst,                      // sync reset, high
  input wire cmr_pkg::cmr_group_t accGroup,      // group of access
  input wire logic [4:0] accIndex,               // byte within group
  input wire logic accWrite,                     // write strobe, pulse
  input wire logic accRead,                      // read strobe, pulse
  input wire logic [7:0] accWdata,               // write data
  input wire logic [191:0] cellResultIn,         // 12 x 12-bit cells in the low 144 of 192 bits
  input wire logic [11:0] cellUnderIn,           // cell under flags
  input wire logic [11:0] cellOverIn,            // cell over flags
  input wire logic [11:0] extTemp1In,            // external temp 1
  input wire logic [11:0] extTemp2In,            // external temp 2
  input wire logic [11:0] intTempIn,             // internal temp
  input wire logic thermalEventIn,               // shutdown event pulse
  input wire logic [7:0] packetCheckIn,          // packet check byte
  input wire logic tempGroupDone,                // temp group read ended
  output logic [7:0] accRdata,                   // read data, registered
  output logic accRvalid,                        // read data valid
  output logic accRdenied,                       // read refused
  output logic watchdogOutCtrl,                  // watchdog output ctrl
  output logic gpio1Ctrl,                        // gpio1 control
  output logic gpio2Ctrl,                        // gpio2 control
  output logic pollingStyleSel,                  // polling style
  output logic tenCellSel,                       // ten-cell select
  output logic [11:0] cellDischargeEn,           // discharge enables
  output logic [11:0] cellIrqMask,               // interrupt masks
  output logic [7:0] underThreshold,             // under threshold
  output logic [7:0] overThreshold,              // over threshold
  output logic comparatorOn,                     // comparator enabled
  output logic refPowerDown,                     // ref down between meas
  output logic standbyMode,                      // standby
  output logic [31:0] measCycles,                // cycles per measurement
  output logic [31:0] cmpPeriodCycles            // comparator period cycles
);
  import cmr_pkg::*;

  logic [7:0] cfg_q [CFG_BYTES];
  logic thermalFlag_q;
  logic [2:0] dutyCode;
  logic [7:0] cellBytes [CELL_BYTES];
  logic [7:0] tempBytes [TEMP_BYTES];
  logic [7:0] flagBytes [FLAG_BYTES];
  logic [11:0] flagUnder;
  logic [11:0] flagOver;
  logic [7:0] rdata_d;
  logic denied_d;

  // configuration bytes; only the config group is writable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q[0] <= CFG0_RESET;
      cfg_q[1] <= CFG1_RESET;
      cfg_q[2] <= CFG2_RESET;
      cfg_q[3] <= CFG3_RESET;
      cfg_q[4] <= CFG4_RESET;
      cfg_q[5] <= CFG5_RESET;
    end else if (accWrite && accGroup == GRP_CFG &&
                 accIndex < 5'(CFG_BYTES)) begin
      cfg_q[accIndex[2:0]] <= accWdata;
    end
  end

  assign dutyCode = cfg_q[0][B0_CDC_LSB +: 3];

  // field outputs registered from the config flops, one cycle behind
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdogOutCtrl <= 1'b0;
      gpio1Ctrl <= 1'b0;
      gpio2Ctrl <= 1'b0;
      pollingStyleSel <= 1'b0;
      tenCellSel <= 1'b0;
      cellDischargeEn <= 12'h000;
      cellIrqMask <= 12'h000;
      underThreshold <= 8'h00;
      overThreshold <= 8'h00;
    end else begin
      watchdogOutCtrl <= cfg_q[0][B0_WDT_BIT];
      gpio2Ctrl <= cfg_q[0][B0_GPIO2_BIT];
      gpio1Ctrl <= cfg_q[0][B0_GPIO1_BIT];
      pollingStyleSel <= cfg_q[0][B0_POLL_BIT];
      tenCellSel <= cfg_q[0][B0_TEN_BIT];
      cellDischargeEn <= {cfg_q[2][3:0], cfg_q[1]};
      cellIrqMask <= {cfg_q[3], cfg_q[2][B2_MASK_LSB +: 4]};
      underThreshold <= cfg_q[4];
      overThreshold <= cfg_q[5];
    end
  end

  // duty-cycle decode; one cycle behind the config write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comparatorOn <= 1'b0;
      refPowerDown <= 1'b1;
      standbyMode <= 1'b1;
      measCycles <= 32'h0;
      cmpPeriodCycles <= 32'h0;
    end else begin
      standbyMode <= (dutyCode == 3'h0);
      comparatorOn <= (dutyCode > 3'h1);
      refPowerDown <= (dutyCode == 3'h0) || (dutyCode > 3'h4);
      case (dutyCode)
        3'h0: begin
          measCycles <= 32'h0;
          cmpPeriodCycles <= 32'h0;
        end
        3'h1: begin
          measCycles <= 32'(MEAS_FAST_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'h0;
        end
        3'h2: begin
          measCycles <= 32'(MEAS_FAST_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P13_MS) * CYC_PER_MS;
        end
        3'h3: begin
          measCycles <= 32'(MEAS_FAST_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P130_MS) * CYC_PER_MS;
        end
        3'h4: begin
          measCycles <= 32'(MEAS_FAST_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P500_MS) * CYC_PER_MS;
        end
        3'h5: begin
          measCycles <= 32'(MEAS_SLOW_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P130_MS) * CYC_PER_MS;
        end
        3'h6: begin
          measCycles <= 32'(MEAS_SLOW_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P500_MS) * CYC_PER_MS;
        end
        default: begin
          measCycles <= 32'(MEAS_SLOW_MS) * CYC_PER_MS;
          cmpPeriodCycles <= 32'(CMP_P2000_MS) * CYC_PER_MS;
        end
      endcase
    end
  end

  // sticky shutdown status; a new event beats the read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thermalFlag_q <= 1'b0;
    end else if (thermalEventIn) begin
      thermalFlag_q <= 1'b1;
    end else if (tempGroupDone) begin
      thermalFlag_q <= 1'b0;
    end
  end

  // cell result packing, one packer per pair
  genvar gp;
  generate
    for (gp = 0; gp < CELL_COUNT / 2; gp++) begin : g_pair
      cmr_pair_pack u_pack (
        .firstRes(cellResultIn[24*gp +: RES_W]),
        .secondRes(cellResultIn[24*gp + RES_W +: RES_W]),
        .byteLo(cellBytes[3*gp]),
        .byteMid(cellBytes[3*gp + 1]),
        .byteHi(cellBytes[3*gp + 2])
      );
    end
  endgenerate

  // external temps share the pair packing
  cmr_pair_pack u_temp_pack (
    .firstRes(extTemp1In),
    .secondRes(extTemp2In),
    .byteLo(tempBytes[0]),
    .byteMid(tempBytes[1]),
    .byteHi(tempBytes[2])
  );

  assign tempBytes[3] = intTempIn[7:0];
  assign tempBytes[4] = {REV_CODE, thermalFlag_q, intTempIn[11:8]};

  // masking hides cells 11 and 12 in ten-cell mode
  assign flagUnder = tenCellSel ? {2'b00, cellUnderIn[9:0]} : cellUnderIn;
  assign flagOver = tenCellSel ? {2'b00, cellOverIn[9:0]} : cellOverIn;

  // interleave under (even) and over (odd) per cell
  genvar gf;
  generate
    for (gf = 0; gf < CELL_COUNT; gf++) begin : g_flag
      assign flagBytes[gf / 4][2 * (gf % 4)] = flagUnder[gf];
      assign flagBytes[gf / 4][2 * (gf % 4) + 1] = flagOver[gf];
    end
  endgenerate

  // read mux; out-of-range index reads zero, except in the packet check group, which ignores the index
  always_comb begin
    rdata_d = 8'h00;
    denied_d = 1'b0;
    case (accGroup)
      GRP_CFG: begin
        if (accIndex < 5'(CFG_BYTES)) rdata_d = cfg_q[accIndex[2:0]];
      end
      GRP_CELL: begin
        if (accIndex >= 5'(TEN_CELL_FIRST_HIDDEN) && tenCellSel) begin
          denied_d = 1'b1;
        end else if (accIndex < 5'(CELL_BYTES)) begin
          rdata_d = cellBytes[accIndex];
        end
      end
      GRP_FLAG: begin
        if (accIndex < 5'(FLAG_BYTES)) rdata_d = flagBytes[accIndex[1:0]];
      end
      GRP_TEMP: begin
        if (accIndex < 5'(TEMP_BYTES)) rdata_d = tempBytes[accIndex[2:0]];
      end
      GRP_PEC: begin
        rdata_d = packetCheckIn;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accRdata <= 8'h00;
      accRvalid <= 1'b0;
      accRdenied <= 1'b0;
    end else begin
      accRvalid <= accRead && !denied_d;
      accRdenied <= accRead && denied_d;
      accRdata <= (accRead && !denied_d) ? rdata_d : 8'h00;
    end
  end

  // checks
  AST_CFG_READBACK: assert property (@(posedge clk) disable iff (sys_rst)
    accWrite && accGroup == GRP_CFG && accIndex == 5'd4 ##1 !accWrite ##1
    accRead && accGroup == GRP_CFG && accIndex == 5'd4 && !accWrite
    |=> accRdata == $past(accWdata, 3))
    else $error("config byte4 readback mismatch");
  AST_WDT_FIELD: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 watchdogOutCtrl == $past(cfg_q[0][7]))
    else $error("watchdog control not from byte0 bit7");
  AST_DISCHARGE: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 cellDischargeEn[11:8] == $past(cfg_q[2][3:0]))
    else $error("discharge 9-12 wrong");
  AST_HIDDEN_READ: assert property (@(posedge clk) disable iff (sys_rst)
    accRead && tenCellSel && accGroup == GRP_CELL && accIndex == 5'd16
    |=> accRdenied && !accRvalid)
    else $error("hidden cell byte was readable");
  AST_FLAG_TEN: assert property (@(posedge clk) disable iff (sys_rst)
    tenCellSel |-> flagBytes[2][7:4] == 4'h0)
    else $error("cell 11/12 flags set in ten-cell mode");
  AST_FLAG_POS: assert property (@(posedge clk) disable iff (sys_rst)
    !tenCellSel |-> flagBytes[2][7] == cellOverIn[11])
    else $error("cell 12 over flag misplaced");
  AST_STANDBY: assert property (@(posedge clk) disable iff (sys_rst)
    dutyCode == 3'h0 |=> standbyMode && refPowerDown && !comparatorOn)
    else $error("code 0 not standby");
  AST_FAST_MEAS: assert property (@(posedge clk) disable iff (sys_rst)
    dutyCode == 3'h3 |=> measCycles == 32'd1300000 &&
    cmpPeriodCycles == 32'd13000000 && !refPowerDown)
    else $error("code 3 timing wrong");
  AST_SLOW_MEAS: assert property (@(posedge clk) disable iff (sys_rst)
    dutyCode == 3'h7 |=> measCycles == 32'd2100000 &&
    cmpPeriodCycles == 32'd200000000 && refPowerDown)
    else $error("code 7 timing wrong");
  AST_THERMAL_SHUTDOWN_FLAG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    tempGroupDone && !thermalEventIn |=> tempBytes[4][4] == 1'b0)
    else $error("shutdown bit not cleared");
  AST_REV: assert property (@(posedge clk) disable iff (sys_rst)
    tempBytes[4][7:5] == REV_CODE)
    else $error("revision field wrong");
  AST_RO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    accWrite && accGroup != GRP_CFG |=> $stable(cfg_q[0]))
    else $error("read-only write changed config");
  AST_PEC: assert property (@(posedge clk) disable iff (sys_rst)
    accRead && accGroup == GRP_PEC |=> accRdata == $past(packetCheckIn))
    else $error("packet check byte wrong");

  COV_TEN_DENY: cover property (@(posedge clk) accRdenied);
  COV_THERMAL_SHUTDOWN_FLAG: cover property (@(posedge clk) thermalFlag_q ##[1:20] !thermalFlag_q);
  COV_CFG_WR: cover property (@(posedge clk) accWrite && accGroup == GRP_CFG);
  COV_SLOW: cover property (@(posedge clk) refPowerDown && comparatorOn);
endmodule // cmr_regmap

// ===== testbench/cmr_host_model.sv
// host model: drives the register access port and collects answers
module cmr_host_model
  import cmr_pkg::*;
(
  input wire logic clk,                 // bench clock
  output cmr_pkg::cmr_group_t accGroup, // group select
  output logic [4:0] accIndex,          // byte index
  output logic accWrite,                // write strobe
  output logic accRead,                 // read strobe
  output logic [7:0] accWdata,          // write data
  input wire logic [7:0] accRdata,      // read data
  input wire logic accRvalid,           // answer valid
  input wire logic accRdenied           // answer refused
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero
  initial begin
    accGroup = GRP_CFG;
    accIndex = 5'h00;
    accWrite = 1'b0;
    accRead = 1'b0;
    accWdata = 8'h00;
  end

  // one write, held until the taking edge, data scrambled afterwards
  task automatic wr(input cmr_group_t g, input int i, input logic [7:0] d);
    @(posedge clk);
    #1;
    accGroup = g;
    accIndex = 5'(i);
    accWdata = d;
    accWrite = 1'b1;
    @(posedge clk);
    #1;
    accWrite = 1'b0;
    accWdata = ~d;
  endtask

  // one read; the answer stands one cycle so it is taken right away
  task automatic rd(input cmr_group_t g, input int i, output logic [7:0] d,
                    output logic v, output logic dn);
    @(posedge clk);
    #1;
    accGroup = g;
    accIndex = 5'(i);
    accRead = 1'b1;
    @(posedge clk);
    #1;
    accRead = 1'b0;
    d = accRdata;
    v = accRvalid;
    dn = accRdenied;
  endtask
endmodule // cmr_host_model

// ===== testbench/cell_monitor_register_map_tb.sv
// self-checking bench for the cell monitor register map
module cell_monitor_register_map_tb
  import cmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, accWrite, accRead, thermalEventIn, tempGroupDone;
  cmr_group_t accGroup;
  logic [4:0] accIndex;
  logic [7:0] accWdata, accRdata, packetCheckIn, uth, oth;
  logic accRvalid, accRdenied, wdo, g1, g2, poll, ten, cmpOn, refDn, stby;
  logic [191:0] cellResultIn;
  logic [11:0] cellUnderIn, cellOverIn, ext1, ext2, intT, dis, msk;
  logic [31:0] meas, cmpP;
  int n_fail = 0;
  int total_checks = 0;

  cmr_regmap DUT (.clk(clk), .sys_rst(sys_rst), .accGroup(accGroup),
    .accIndex(accIndex), .accWrite(accWrite), .accRead(accRead),
    .accWdata(accWdata), .cellResultIn(cellResultIn),
    .cellUnderIn(cellUnderIn), .cellOverIn(cellOverIn), .extTemp1In(ext1),
    .extTemp2In(ext2), .intTempIn(intT), .thermalEventIn(thermalEventIn),
    .packetCheckIn(packetCheckIn), .tempGroupDone(tempGroupDone),
    .accRdata(accRdata), .accRvalid(accRvalid), .accRdenied(accRdenied),
    .watchdogOutCtrl(wdo), .gpio1Ctrl(g1), .gpio2Ctrl(g2),
    .pollingStyleSel(poll), .tenCellSel(ten), .cellDischargeEn(dis),
    .cellIrqMask(msk), .underThreshold(uth), .overThreshold(oth),
    .comparatorOn(cmpOn), .refPowerDown(refDn), .standbyMode(stby),
    .measCycles(meas), .cmpPeriodCycles(cmpP));

  cmr_host_model u_host (.clk(clk), .accGroup(accGroup),
    .accIndex(accIndex), .accWrite(accWrite), .accRead(accRead),
    .accWdata(accWdata), .accRdata(accRdata), .accRvalid(accRvalid),
    .accRdenied(accRdenied));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // distinct value per cell so a swapped nibble shows up
  function automatic logic [11:0] cellv(int n);
    return 12'(n * 12'h1F3 + 12'h05A);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic rdchk(cmr_group_t gr, int i, logic [7:0] e, string nm);
    logic [7:0] d;
    logic v, dn;
    u_host.rd(gr, i, d, v, dn);
    chk({nm, " valid"}, 32'h1, {31'h0, v});
    chk(nm, {24'h0, e}, {24'h0, d});
  endtask

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic test_reset();
    rdchk(GRP_CFG, 0, CFG0_RESET, "cfg0 reset");
    for (int i = 1; i < 6; i++) rdchk(GRP_CFG, i, 8'h00, "cfg reset");
    chk("reset duty", 32'h6, {29'h0, stby, refDn, cmpOn});
    chk("reset fields", {27'h0, CFG0_RESET[7:3]}, {27'h0, wdo, g2, g1, poll, ten});
  endtask

  task automatic test_cfg();
    logic [7:0] v[6] = '{8'hB9, 8'h5A, 8'hC3, 8'h96, 8'h7E, 8'hE1};
    for (int i = 0; i < 6; i++) u_host.wr(GRP_CFG, i, v[i]);
    u_host.wr(GRP_CFG, 6, 8'hFF);
    for (int i = 0; i < 6; i++) rdchk(GRP_CFG, i, v[i], "cfg rb");
    rdchk(GRP_CFG, 6, 8'h00, "cfg6");
    chk("byte0 fields", 32'h17, {27'h0, wdo, g2, g1, poll, ten});
    chk("discharge", 32'h35A, {20'h0, dis});
    chk("irq mask", 32'h96C, {20'h0, msk});
    chk("thresholds", 32'h7EE1, {16'h0, uth, oth});
    u_host.wr(GRP_CFG, 4, 8'h3C);
    rdchk(GRP_CFG, 4, 8'h3C, "cfg4 wr rd");
  endtask

  // every duty code, decode settles one cycle after the write edge, checked after two
  task automatic test_duty();
    int cmpMs[8] = '{0, 0, 13, 130, 500, 130, 500, 2000};
    int ms;
    for (int c = 0; c < 8; c++) begin
      u_host.wr(GRP_CFG, 0, 8'(c));
      repeat (2) @(posedge clk);
      #1;
      ms = (c == 0) ? 0 : ((c < 5) ? MEAS_FAST_MS : MEAS_SLOW_MS);
      chk("standby", 32'(c == 0), {31'h0, stby});
      chk("ref down", 32'(c == 0 || c >= 5), {31'h0, refDn});
      chk("cmp on", 32'(c >= 2), {31'h0, cmpOn});
      chk("meas", 32'(ms) * CYC_PER_MS, meas);
      chk("cmp period", 32'(cmpMs[c]) * CYC_PER_MS, cmpP);
    end
  endtask

  task automatic test_cells();
    logic [11:0] a, b;
    logic [7:0] d;
    logic v, dn;
    u_host.wr(GRP_CELL, 0, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      a = cellv(2 * k + 1);
      b = cellv(2 * k + 2);
      rdchk(GRP_CELL, 3 * k, a[7:0], "cell lo");
      rdchk(GRP_CELL, 3 * k + 1, {b[3:0], a[11:8]}, "cell mid");
      rdchk(GRP_CELL, 3 * k + 2, b[11:4], "cell hi");
    end
    u_host.wr(GRP_CFG, 0, 8'h08);
    @(posedge clk);
    for (int i = 15; i < 18; i++) begin
      u_host.rd(GRP_CELL, i, d, v, dn);
      chk("hidden cell", 32'h2, {30'h0, dn, v});
    end
  endtask

  // ten-cell mode first (left on by the cell test), then twelve
  task automatic test_flags();
    logic [7:0] e;
    int idx;
    for (int t = 1; t >= 0; t--) begin
      if (t == 0) u_host.wr(GRP_CFG, 0, 8'h00);
      @(posedge clk);
      for (int f = 0; f < 3; f++) begin
        e = 8'h00;
        for (int i = 0; i < 4; i++) begin
          idx = 4 * f + i;
          if (!(t == 1 && idx >= 10)) begin
            e[2 * i] = cellUnderIn[idx];
            e[2 * i + 1] = cellOverIn[idx];
          end
        end
        rdchk(GRP_FLAG, f, e, "flags");
      end
    end
  endtask

  task automatic test_temp();
    rdchk(GRP_TEMP, 0, ext1[7:0], "temp0");
    rdchk(GRP_TEMP, 1, {ext2[3:0], ext1[11:8]}, "temp1");
    rdchk(GRP_TEMP, 2, ext2[11:4], "temp2");
    rdchk(GRP_TEMP, 3, intT[7:0], "temp3");
    rdchk(GRP_TEMP, 4, {REV_CODE, 1'b0, intT[11:8]}, "temp4");
    @(posedge clk);
    #1;
    thermalEventIn = 1'b1;
    @(posedge clk);
    #1;
    thermalEventIn = 1'b0;
    rdchk(GRP_TEMP, 4, {REV_CODE, 1'b1, intT[11:8]}, "shutdown set");
    tempGroupDone = 1'b1;
    @(posedge clk);
    #1;
    tempGroupDone = 1'b0;
    rdchk(GRP_TEMP, 4, {REV_CODE, 1'b0, intT[11:8]}, "shutdown clr");
    // event and clear in one cycle: the event must win
    thermalEventIn = 1'b1;
    tempGroupDone = 1'b1;
    @(posedge clk);
    #1;
    thermalEventIn = 1'b0;
    tempGroupDone = 1'b0;
    rdchk(GRP_TEMP, 4, {REV_CODE, 1'b1, intT[11:8]}, "set wins");
    rdchk(GRP_PEC, 0, packetCheckIn, "packet check");
  endtask

  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    thermalEventIn = 1'b0;
    tempGroupDone = 1'b0;
    cellUnderIn = 12'hA5C;
    cellOverIn = 12'hC36;
    ext1 = 12'hABC;
    ext2 = 12'h123;
    intT = 12'h9E7;
    packetCheckIn = 8'h5A;
    for (int n = 1; n <= 12; n++) cellResultIn[12 * (n - 1) +: 12] = cellv(n);
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    test_reset();
    test_cfg();
    test_duty();
    test_cells();
    test_flags();
    test_temp();
    test_done();
  end
endmodule // cell_monitor_register_map_tb
